// ### rtl/prsc_phy_rx_status_and_config_regs.sv
// top: axi4-lite register bank and rx status sideband of the phy controller
`timescale 1ns/1ps
module prsc_phy_rx_status_and_config_regs
    import prsc_pkg::*;
#(
    parameter bit IS_HDMI = 1'b0
)
(
    input wire logic clk,
    input wire logic reset,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transceiver side
    input wire prsc_xcvr_status_s xcvr_status,
    output prsc_xcvr_control_s xcvr_control,
    // rx status sideband stream
    input wire logic rx_status_sb_tready,
    output logic [SB_DP_W-1:0] rx_status_sideband_word,
    output logic rx_status_sb_tvalid
);
    logic [31:0] bank_select;
    logic [31:0] reference_clock_select;
    logic [31:0] pll_reset_control;
    logic [31:0] tx_lane_initialization;
    logic [31:0] pll_lock_status;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_held;
    logic w_held;
    logic wr_fire;
    logic ar_fire;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // byte-lane merge, masked to the implemented bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // word offset compare; the low two address bits are ignored
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] ofs);
        return addr[ADDR_W-1:2] == ofs[9:2];
    endfunction

    // -----------------------------------------------------------------
    // write channel
    // -----------------------------------------------------------------
    // address and data may come in either order; each is held until both are
    // in and the response has been taken, which throttles to one write
    // in flight and keeps bvalid honest
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end
        else if (s_axi_awready && s_axi_awvalid)
        begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else if (s_axi_wready && s_axi_wvalid)
        begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awready && s_axi_awvalid);
            s_axi_wready <= !w_held && !(s_axi_wready && s_axi_wvalid);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // writable registers
    // -----------------------------------------------------------------
    // read-only and reserved offsets fall through with no store
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bank_select <= RST_BANK_SELECT;
            reference_clock_select <= RST_REFCLK_SELECT;
            pll_reset_control <= RST_PLL_RESET;
            tx_lane_initialization <= RST_TX_INIT;
        end
        else if (wr_fire)
        begin
            if (hit(wr_addr, OFS_BANK_SELECT))
            begin
                bank_select <= merge(bank_select, wr_data, wr_strb, MASK_BANK_SELECT);
            end
            if (hit(wr_addr, OFS_REFCLK_SELECT))
            begin
                reference_clock_select <= merge(reference_clock_select, wr_data, wr_strb,
                                                MASK_REFCLK_SELECT);
            end
            if (hit(wr_addr, OFS_PLL_RESET))
            begin
                pll_reset_control <= merge(pll_reset_control, wr_data, wr_strb,
                                           MASK_PLL_RESET);
            end
            if (hit(wr_addr, OFS_TX_INIT))
            begin
                tx_lane_initialization <= merge(tx_lane_initialization, wr_data, wr_strb,
                                                MASK_TX_INIT);
            end
        end
    end

    // -----------------------------------------------------------------
    // status capture
    // -----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pll_lock_status <= '0;
        end
        else
        begin
            pll_lock_status <= '0;
            pll_lock_status[LANES-1:0] <= xcvr_status.channel_pll_locked;
            pll_lock_status[LOCK_QPLL0_POS] <= xcvr_status.quad_pll0_locked;
            pll_lock_status[LOCK_QPLL1_POS] <= xcvr_status.quad_pll1_locked;
        end
    end

    // -----------------------------------------------------------------
    // read channel
    // -----------------------------------------------------------------
    assign ar_fire = s_axi_arready && s_axi_arvalid;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !ar_fire;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            if (hit(s_axi_araddr, OFS_VERSION))
            begin
                s_axi_rdata <= {VER_MAJOR, VER_MINOR, VER_REVISION, VER_PATCH,
                                VER_INTERNAL};
            end
            if (hit(s_axi_araddr, OFS_BANK_SELECT))
            begin
                s_axi_rdata <= bank_select;
            end
            if (hit(s_axi_araddr, OFS_REFCLK_SELECT))
            begin
                s_axi_rdata <= reference_clock_select;
            end
            if (hit(s_axi_araddr, OFS_PLL_RESET))
            begin
                s_axi_rdata <= pll_reset_control;
            end
            if (hit(s_axi_araddr, OFS_PLL_LOCK))
            begin
                s_axi_rdata <= pll_lock_status;
            end
            if (hit(s_axi_araddr, OFS_TX_INIT))
            begin
                s_axi_rdata <= tx_lane_initialization;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // transceiver controls
    // -----------------------------------------------------------------
    // one register stage after the stored bit so every output is a flop
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            xcvr_control <= '0;
        end
        else
        begin
            for (int i = 0; i < LANES; i++)
            begin
                xcvr_control.transceiver_tx_full_reset[i] <=
                    tx_lane_initialization[i*TXI_LANE_STRIDE+TXI_FULL_RESET_POS];
                xcvr_control.tx_pma_reset_a[i] <=
                    tx_lane_initialization[i*TXI_LANE_STRIDE+TXI_PMA_RESET_POS];
                xcvr_control.tx_pcs_reset_b[i] <=
                    tx_lane_initialization[i*TXI_LANE_STRIDE+TXI_PCS_RESET_POS];
                xcvr_control.tx_user_logic_ready[i] <=
                    tx_lane_initialization[i*TXI_LANE_STRIDE+TXI_USER_READY_POS];
                xcvr_control.pll_and_transceiver_reset[i] <=
                    tx_lane_initialization[i*TXI_LANE_STRIDE+TXI_PLL_AND_TRANSCEIVER_RESET_POS];
            end
            xcvr_control.channel_pll_reset <= pll_reset_control[PLL_RST_CPLL_POS];
            xcvr_control.quad_pll0_reset <= pll_reset_control[PLL_RST_QPLL0_POS];
            xcvr_control.quad_pll1_reset <= pll_reset_control[PLL_RST_QPLL1_POS];
            xcvr_control.quad_pll0_refclk_source <=
                reference_clock_select[QPLL0_REFCLK_POS +: 4];
            xcvr_control.channel_pll_refclk_source <=
                reference_clock_select[CPLL_REFCLK_POS +: 4];
            xcvr_control.quad_pll1_refclk_source <=
                reference_clock_select[QPLL1_REFCLK_POS +: 4];
            xcvr_control.rx_system_clock_source <=
                reference_clock_select[RX_SYSCLK_POS +: 2];
            xcvr_control.tx_system_clock_source <=
                reference_clock_select[TX_SYSCLK_POS +: 2];
            xcvr_control.rx_pll_clock_source <= reference_clock_select[RX_PLLCLK_POS +: 2];
            xcvr_control.tx_pll_clock_source <= reference_clock_select[TX_PLLCLK_POS +: 2];
            xcvr_control.tx_bank_select <= bank_select[4:0];
            xcvr_control.rx_bank_select <= bank_select[12:8];
        end
    end

    // -----------------------------------------------------------------
    // rx status sideband
    // -----------------------------------------------------------------
    prsc_rx_status_sb #(
        .IS_HDMI(IS_HDMI)
    ) u_status_sb (
        .clk(clk),
        .reset(reset),
        .status(xcvr_status),
        .rx_system_clock_source(reference_clock_select[RX_SYSCLK_POS +: 2]),
        .tready(rx_status_sb_tready),
        .rx_status_sideband_word(rx_status_sideband_word),
        .tvalid(rx_status_sb_tvalid)
    );

    // protection type carries no meaning for this bank
    logic [5:0] unused_prot;
    assign unused_prot = {s_axi_awprot, s_axi_arprot};
endmodule

// ### rtl/prsc_pkg.sv
// package of register map, field layout and carrier types for the phy rx status bank
// Notes on behaviour
// - all rx status sideband bits are driven from the register clock.
// - displayport rx reset done per lane sits at bits 0, 3, 6, 9.
// - displayport lane lock at bits 1,4,7,10; channel or quad pll by rx clock source.
// - displayport byte aligned per lane sits at bits 2, 5, 8, 11.
// - hdmi bit 0 is link ready once rx reset done is seen.
// - hdmi bit 1 is video ready once receive clock manager is stable.
// - configuration registers read and write over the axi4-lite slave.
// - undefined register bits read as zero.
// - control registers hold zero after reset unless defined otherwise.
// - only offsets are decoded; base address comes from the interconnect.
// - version register at 0x0000 with major, minor, revision, patch, internal fields.
// - bank select at 0x000c, tx bank bits 4:0, rx bank 12:8, reset zero.
// - refclk select at 0x0010: quad pll0 3:0, channel pll 7:4, quad pll1 11:8.
// - bits 27:24 system clock sources, 31:28 pll clock sources, 23:12 reserved.
// - pll reset at 0x0014: channel bit 0, quad0 bit 1, quad1 bit 2.
// - pll lock status at 0x0018: channel locks bits 0-3, quad0 bit 4, quad1 bit 5.
// - tx init at 0x001c, one byte per lane: resets, user ready, pll reset.
// - rx status sideband on axi4-stream, 16 bits displayport, 2 bits hdmi.
package prsc_pkg;
    localparam int ADDR_W = 10;
    localparam int LANES = 4;
    localparam logic [9:0] OFS_VERSION = 10'h000;
    localparam logic [9:0] OFS_BANK_SELECT = 10'h00c;
    localparam logic [9:0] OFS_REFCLK_SELECT = 10'h010;
    localparam logic [9:0] OFS_PLL_RESET = 10'h014;
    localparam logic [9:0] OFS_PLL_LOCK = 10'h018;
    localparam logic [9:0] OFS_TX_INIT = 10'h01c;
    // writable bit masks; everything else is reserved
    localparam logic [31:0] MASK_BANK_SELECT = 32'h00001f1f;
    localparam logic [31:0] MASK_REFCLK_SELECT = 32'hff000fff;
    localparam logic [31:0] MASK_PLL_RESET = 32'h00000007;
    localparam logic [31:0] MASK_TX_INIT = 32'h8f8f8f8f;
    localparam logic [31:0] RST_BANK_SELECT = 32'h00000000;
    localparam logic [31:0] RST_REFCLK_SELECT = 32'h00000000;
    localparam logic [31:0] RST_PLL_RESET = 32'h00000000;
    localparam logic [31:0] RST_TX_INIT = 32'h00000000;
    // version fields; value arbitrary
    localparam logic [7:0] VER_MAJOR = 8'h01;
    localparam logic [7:0] VER_MINOR = 8'h00;
    localparam logic [3:0] VER_REVISION = 4'h0;
    localparam logic [3:0] VER_PATCH = 4'h0;
    localparam logic [7:0] VER_INTERNAL = 8'h00;
    localparam int VER_MAJOR_POS = 24;
    localparam int VER_MINOR_POS = 16;
    localparam int VER_REVISION_POS = 12;
    localparam int VER_PATCH_POS = 8;
    // reference clock select field positions
    localparam int QPLL0_REFCLK_POS = 0;
    localparam int CPLL_REFCLK_POS = 4;
    localparam int QPLL1_REFCLK_POS = 8;
    localparam int RX_SYSCLK_POS = 24;
    localparam int TX_SYSCLK_POS = 26;
    localparam int RX_PLLCLK_POS = 28;
    localparam int TX_PLLCLK_POS = 30;
    // pll reset and lock field positions
    localparam int PLL_RST_CPLL_POS = 0;
    localparam int PLL_RST_QPLL0_POS = 1;
    localparam int PLL_RST_QPLL1_POS = 2;
    localparam int LOCK_QPLL0_POS = 4;
    localparam int LOCK_QPLL1_POS = 5;
    // tx init per-lane byte layout
    localparam int TXI_LANE_STRIDE = 8;
    localparam int TXI_FULL_RESET_POS = 0;
    localparam int TXI_PMA_RESET_POS = 1;
    localparam int TXI_PCS_RESET_POS = 2;
    localparam int TXI_USER_READY_POS = 3;
    localparam int TXI_PLL_AND_TRANSCEIVER_RESET_POS = 7;
    // rx status sideband layout
    localparam int SB_DP_W = 16;
    localparam int SB_HDMI_W = 2;
    localparam int SB_LANE_STRIDE = 3;
    localparam int SB_RESET_DONE_POS = 0;
    localparam int SB_LOCK_POS = 1;
    localparam int SB_ALIGNED_POS = 2;
    localparam int SB_LINK_READY_POS = 0;
    localparam int SB_VIDEO_READY_POS = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;

    typedef struct packed {
        logic [LANES-1:0] rx_reset_done;
        logic [LANES-1:0] channel_pll_locked;
        logic [LANES-1:0] rx_byte_aligned;
        logic quad_pll0_locked;
        logic quad_pll1_locked;
        logic rx_video_clock_stable;
    } prsc_xcvr_status_s;

    typedef struct packed {
        logic [LANES-1:0] transceiver_tx_full_reset;
        logic [LANES-1:0] tx_pma_reset_a;
        logic [LANES-1:0] tx_pcs_reset_b;
        logic [LANES-1:0] tx_user_logic_ready;
        logic [LANES-1:0] pll_and_transceiver_reset;
        logic channel_pll_reset;
        logic quad_pll0_reset;
        logic quad_pll1_reset;
        logic [3:0] quad_pll0_refclk_source;
        logic [3:0] channel_pll_refclk_source;
        logic [3:0] quad_pll1_refclk_source;
        logic [1:0] rx_system_clock_source;
        logic [1:0] tx_system_clock_source;
        logic [1:0] rx_pll_clock_source;
        logic [1:0] tx_pll_clock_source;
        logic [4:0] tx_bank_select;
        logic [4:0] rx_bank_select;
    } prsc_xcvr_control_s;
endpackage

// ### rtl/prsc_rx_status_sb.sv
// rx status sideband builder for displayport and hdmi variants
`timescale 1ns/1ps
module prsc_rx_status_sb
    import prsc_pkg::*;
#(
    parameter bit IS_HDMI = 1'b0
)
(
    input wire logic clk,
    input wire logic reset,
    input wire prsc_xcvr_status_s status,
    input wire logic [1:0] rx_system_clock_source,
    input wire logic tready,
    output logic [SB_DP_W-1:0] rx_status_sideband_word,
    output logic tvalid
);
    logic [SB_DP_W-1:0] next_word;

    // -----------------------------------------------------------------
    // word assembly
    // -----------------------------------------------------------------
    // only bit 0 of the source select steers the lock mux, for all lanes
    always_comb
    begin
        next_word = '0;
        if (IS_HDMI)
        begin
            next_word[SB_LINK_READY_POS] = &status.rx_reset_done;
            next_word[SB_VIDEO_READY_POS] = status.rx_video_clock_stable;
        end
        else
        begin
            for (int i = 0; i < LANES; i++)
            begin
                next_word[i*SB_LANE_STRIDE+SB_RESET_DONE_POS] = status.rx_reset_done[i];
                next_word[i*SB_LANE_STRIDE+SB_LOCK_POS] = rx_system_clock_source[0] ?
                    status.quad_pll0_locked : status.channel_pll_locked[i];
                next_word[i*SB_LANE_STRIDE+SB_ALIGNED_POS] = status.rx_byte_aligned[i];
            end
        end
    end

    // -----------------------------------------------------------------
    // stream register
    // -----------------------------------------------------------------
    // status is a level, so the word is refreshed every cycle; tready only
    // marks that the sink looked, no beat is ever held back
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rx_status_sideband_word <= '0;
            tvalid <= 1'b0;
        end
        else
        begin
            rx_status_sideband_word <= next_word;
            tvalid <= 1'b1;
        end
    end

    logic unused_ready;
    assign unused_ready = tready;
endmodule

// ### sim/prsc_link_partner.sv
// partner model: transceiver status source and link layer sideband sink
`timescale 1ns/1ps
module prsc_link_partner
    import prsc_pkg::*;
(
    input wire logic clk,
    input wire prsc_xcvr_status_s status_next,
    output prsc_xcvr_status_s status,
    output logic tready
);
    // status levels move on the register clock, as the transceiver flags do
    always_ff @(posedge clk)
    begin
        status <= status_next;
    end
    // sink never stalls: the sideband is a level carrier
    assign tready = 1'b1;
endmodule

// ### sim/prsc_phy_rx_status_and_config_regs_bench.sv
// self-checking bench: register access and rx status sideband
`timescale 1ns/1ps
module prsc_phy_rx_status_and_config_regs_bench
    import prsc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, tvalid, tready;
    logic [1:0] bresp, rresp;
    logic [15:0] sb_word;
    prsc_xcvr_status_s st_next = '0, st;
    prsc_xcvr_control_s ctl;
    int err_count = 0, checks = 0;
    localparam logic [31:0] VER = {VER_MAJOR, VER_MINOR, VER_REVISION, VER_PATCH, VER_INTERNAL};
    localparam logic [9:0] RW_A [4] = '{10'h00c, 10'h010, 10'h014, 10'h01c};
    localparam logic [31:0] RW_M [4] = '{32'h00001f1f, 32'hff000fff, 32'h00000007, 32'h8f8f8f8f};
    localparam logic [9:0] RO_A [4] = '{10'h000, 10'h004, 10'h018, 10'h3fc};
    localparam prsc_xcvr_status_s PAT [3] = '{15'h2b3a, 15'h54c5, 15'h7fff};

    always #2.5 clk = ~clk;

    prsc_link_partner u_partner (.clk(clk), .status_next(st_next), .status(st), .tready(tready));
    prsc_phy_rx_status_and_config_regs #(.IS_HDMI(1'b0)) uut (
        .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xcvr_status(st), .xcvr_control(ctl),
        .rx_status_sb_tready(tready), .rx_status_sideband_word(sb_word),
        .rx_status_sb_tvalid(tvalid));

    function automatic logic [15:0] exp_sb(prsc_xcvr_status_s s, logic q);
        logic [15:0] e;
        e = '0;
        for (int i = 0; i < 4; i++) e[3*i +: 3] = {s.rx_byte_aligned[i],
            q ? s.quad_pll0_locked : s.channel_pll_locked[i], s.rx_reset_done[i]};
        return e;
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bready stays high; outputs are sampled at the falling edge, once settled
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge clk);
        {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, s, 2'b11};
        do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 20);
        @(posedge clk);
        {awvalid, wvalid} <= 2'b00;
        do @(negedge clk); while (bvalid !== 1'b1 && ++n < 40);
        chk({29'h0, bvalid, bresp}, 32'h4);
        @(posedge clk);
    endtask

    // rready comes a cycle late so the held answer is exercised
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        int n = 0;
        @(posedge clk);
        {araddr, arvalid} <= {a, 1'b1};
        do @(negedge clk); while (arready !== 1'b1 && ++n < 20);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1 && ++n < 40);
        chk(rdata, e);
        chk({29'h0, rvalid, rresp}, 32'h4);
        @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task t_reset_values;
        rd(10'h000, VER);
        for (int i = 0; i < 4; i++) rd(RW_A[i], 32'h0);
        chk(ctl[31:0], 32'h0);
        $display("test reset_values done");
    endtask

    task t_masks;
        for (int i = 0; i < 4; i++) wr(RW_A[i], 32'hffffffff, 4'hf);
        for (int i = 0; i < 4; i++) rd(RW_A[i], RW_M[i]);
        chk(ctl[31:0], 32'hffffffff);
        wr(10'h010, 32'h6cfff321, 4'hf);
        rd(10'h010, 32'h6c000321);
        chk({12'h0, ctl.quad_pll0_refclk_source, ctl.channel_pll_refclk_source,
            ctl.quad_pll1_refclk_source, ctl.rx_system_clock_source, ctl.tx_system_clock_source,
            ctl.rx_pll_clock_source, ctl.tx_pll_clock_source}, 32'h12339);
        wr(10'h01c, 32'h0000080e, 4'h3);
        rd(10'h01c, 32'h8f8f080e);
        chk({12'h0, ctl.transceiver_tx_full_reset, ctl.tx_pma_reset_a, ctl.tx_pcs_reset_b,
            ctl.tx_user_logic_ready, ctl.pll_and_transceiver_reset}, 32'hcddfc);
        $display("test masks done");
    endtask

    task t_read_only;
        for (int i = 0; i < 4; i++) wr(RO_A[i], 32'hffffffff, 4'hf);
        for (int i = 0; i < 4; i++) rd(RO_A[i], i == 0 ? VER : 32'h0);
        rd(10'h00c, 32'h00001f1f);
        $display("test read_only done");
    endtask

    task t_sideband;
        for (int q = 0; q < 2; q++)
        begin
            wr(10'h010, q == 1 ? 32'h01000000 : 32'h0, 4'hf);
            for (int i = 0; i < 3; i++)
            begin
                @(posedge clk);
                st_next <= PAT[i];
                repeat (4) @(negedge clk);
                chk({16'h0, sb_word}, {16'h0, exp_sb(PAT[i], q == 1)});
                chk({31'h0, tvalid}, 32'h1);
                rd(10'h018, {26'h0, PAT[i].quad_pll1_locked, PAT[i].quad_pll0_locked,
                    PAT[i].channel_pll_locked});
            end
        end
        $display("test sideband done");
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset_values;
        t_masks;
        t_read_only;
        t_sideband;
        wrap_up;
    end
endmodule

// ### sim/prsc_regs_properties.sv
// concurrent checks on the ports of the phy rx status and config register bank
`timescale 1ns/1ps
module prsc_regs_properties
    import prsc_pkg::*;
#(
    parameter bit IS_HDMI = 1'b0
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire prsc_xcvr_status_s xcvr_status,
    input wire prsc_xcvr_control_s xcvr_control,
    input wire logic [SB_DP_W-1:0] rx_status_sideband_word,
    input wire logic rx_status_sb_tvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] w;
    prsc_xcvr_status_s s;
    assign w = rx_status_sideband_word;
    assign s = xcvr_status;
    // sideband lags the status inputs by one stage; skip the edge right after reset
    property p_sb_done; !IS_HDMI && !$past(reset) |-> {w[9], w[6], w[3], w[0]} == $past(s.rx_reset_done); endproperty
    a_sb_done: assert property (p_sb_done) else $error("lane reset done bits wrong");
    property p_sb_lock; !IS_HDMI && !$past(reset) |-> {w[10], w[7], w[4], w[1]} ==
        (xcvr_control.rx_system_clock_source[0] ? {4{$past(s.quad_pll0_locked)}} : $past(s.channel_pll_locked)); endproperty
    a_sb_lock: assert property (p_sb_lock) else $error("lane lock bits wrong");
    property p_sb_align; !IS_HDMI && !$past(reset) |-> {w[11], w[8], w[5], w[2]} == $past(s.rx_byte_aligned); endproperty
    a_sb_align: assert property (p_sb_align) else $error("lane aligned bits wrong");
    property p_sb_hdmi; IS_HDMI && !$past(reset) |->
        w == {14'h0, $past(s.rx_video_clock_stable), &$past(s.rx_reset_done)}; endproperty
    a_sb_hdmi: assert property (p_sb_hdmi) else $error("hdmi ready bits wrong");
    property p_sb_frame; !$past(reset) |-> rx_status_sb_tvalid && w[15:12] == 4'h0; endproperty
    a_sb_frame: assert property (p_sb_frame) else $error("sideband framing wrong");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late or bad");
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
    property p_wr_okay; s_axi_bvalid |-> s_axi_bresp == RESP_OKAY; endproperty
    a_wr_okay: assert property (p_wr_okay) else $error("write response not okay");
    // control outputs move only in the wake of a completed write
    property p_ctl_cause; !$stable(xcvr_control) && !$past(reset) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_ctl_cause: assert property (p_ctl_cause) else $error("control moved without a write");
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_write: cover property (s_axi_bvalid);
    c_quad_sel: cover property (xcvr_control.rx_system_clock_source[0] && s.quad_pll0_locked);
endmodule
bind prsc_phy_rx_status_and_config_regs prsc_regs_properties #(.IS_HDMI(IS_HDMI)) u_props (
    .clk(clk), .reset(reset), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .xcvr_status(xcvr_status), .xcvr_control(xcvr_control),
    .rx_status_sideband_word(rx_status_sideband_word), .rx_status_sb_tvalid(rx_status_sb_tvalid));
